// *** flash_ctl_pkg.sv ***
// Shared opcodes, timing figures and state encodings for the suspend, resume and
// power-down command logic. Assumes a 40 MHz core clock.
package flash_ctl_pkg;

    // Core clock period.
    localparam int CLK_PERIOD_NS = 25;

    // Opcodes handled or filtered by the block.
    localparam logic [7:0] OPC_SUSPEND      = 8'h75;
    localparam logic [7:0] OPC_RESUME       = 8'h7a;
    localparam logic [7:0] OPC_POWERDOWN    = 8'hb9;
    localparam logic [7:0] OPC_RELEASE      = 8'hab;
    localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OPC_BLOCK32_ERASE = 8'h52;
    localparam logic [7:0] OPC_BLOCK64_ERASE = 8'hd8;
    localparam logic [7:0] OPC_CHIP_ERASE_A = 8'hc7;
    localparam logic [7:0] OPC_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OPC_SECREG_ERASE = 8'h44;
    localparam logic [7:0] OPC_PAGE_PROG    = 8'h02;
    localparam logic [7:0] OPC_QUAD_PROG    = 8'h32;
    localparam logic [7:0] OPC_SECREG_PROG  = 8'h42;

    // Serial bit positions within a frame.
    localparam logic [7:0] BITS_OPCODE   = 8'h08;
    localparam logic [7:0] BITS_ID_START = 8'h20;
    localparam logic [7:0] BITS_MAX      = 8'hff;
    localparam logic [2:0] ID_MSB        = 3'h7;

    // Times in nanoseconds; all are longest times, so cycle counts round down.
    localparam int SUSPEND_LATENCY_NS   = 20000;
    localparam int RESUME_BUSY_NS       = 200;
    localparam int POWERDOWN_ENTRY_NS   = 3000;
    localparam int RELEASE_NS           = 3000;
    localparam int RELEASE_WITH_ID_NS   = 1800;

    localparam int SUSPEND_LATENCY_CYC  = SUSPEND_LATENCY_NS / CLK_PERIOD_NS;
    localparam int RESUME_BUSY_CYC      = RESUME_BUSY_NS / CLK_PERIOD_NS;
    localparam int POWERDOWN_ENTRY_CYC  = POWERDOWN_ENTRY_NS / CLK_PERIOD_NS;
    localparam int RELEASE_CYC          = RELEASE_NS / CLK_PERIOD_NS;
    localparam int RELEASE_WITH_ID_CYC  = RELEASE_WITH_ID_NS / CLK_PERIOD_NS;

    localparam int TIMER_W = 12;
    // Suspend drains in half the allowed latency, leaving margin.
    localparam logic [TIMER_W-1:0] DRAIN_LOAD    = TIMER_W'(SUSPEND_LATENCY_CYC / 2);
    localparam logic [TIMER_W-1:0] ENTRY_LOAD    = TIMER_W'(POWERDOWN_ENTRY_CYC - 1);
    localparam logic [TIMER_W-1:0] RELEASE_LOAD  = TIMER_W'(RELEASE_CYC - 1);
    localparam logic [TIMER_W-1:0] RELEASE2_LOAD = TIMER_W'(RELEASE_WITH_ID_CYC - 1);
    localparam logic [TIMER_W-1:0] TIMER_ZERO    = '0;

    // Kind of array operation in progress.
    typedef enum logic [2:0] {
        KIND_NONE         = 3'h0,
        KIND_SECTOR_ERASE = 3'h1,
        KIND_BLOCK_ERASE  = 3'h2,
        KIND_CHIP_ERASE   = 3'h3,
        KIND_PAGE_PROG    = 3'h4,
        KIND_STATUS_WRITE = 3'h5,
        KIND_OTHER        = 3'h6
    } op_kind_t;

    // Array operation sequence, Gray coded along run, drain, pause, resume.
    typedef enum logic [2:0] {
        OP_IDLE   = 3'b000,
        OP_RUN    = 3'b001,
        OP_DRAIN  = 3'b011,
        OP_PAUSED = 3'b010,
        OP_RESUME = 3'b110
    } op_state_t;

    // Power state, Gray coded along normal, entry, down, release.
    typedef enum logic [1:0] {
        PW_NORMAL  = 2'b00,
        PW_ENTER   = 2'b01,
        PW_DOWN    = 2'b11,
        PW_RELEASE = 2'b10
    } pw_state_t;

endpackage

// *** pin_sync.sv ***
// Two-flop synchroniser with edge detection for pins from outside the core clock.
// Assumes the pins change slowly compared with the core clock.
`timescale 1ns/1ps
module pin_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rstn,
    // Asynchronous pins
    input  wire logic [W-1:0] pins,
    // Synchronised level and edges
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= RST_VAL;
            stage2 <= RST_VAL;
            stage3 <= RST_VAL;
        end else begin
            stage1 <= pins;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign level = stage2;
    assign rise  = stage2 & ~stage3;
    assign fall  = ~stage2 & stage3;
endmodule

// *** flash_suspend_resume_powerdown.sv ***
// Suspend, resume, power-down and release/identifier command logic of a serial flash.
// Assumes an array engine that starts and finishes operations and honours op_hold.
`timescale 1ns/1ps
module flash_suspend_resume_powerdown
    import flash_ctl_pkg::*;
#(
    // Value is arbitrary.
    parameter logic [7:0] DEVICE_ID = 8'h5a
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // Serial pins
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic       mosi,
    output logic            miso,
    output logic            miso_oe,
    // Array engine
    input  wire logic       op_start,
    input  wire logic [2:0] op_kind,
    input  wire logic       op_done,
    output logic            op_hold,
    // Status
    output logic            busy,
    output logic            suspend_status_bit,
    output logic            powered_down,
    output logic            cmd_ready,
    // Forwarded commands
    output logic [7:0]      cmd_opcode,
    output logic            cmd_valid,
    output logic            cmd_refused
);

    // Synchronised pins.
    logic       cs_n_s;
    logic       sclk_s;
    logic       mosi_s;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_rise;

    // Serial frame state.
    logic [7:0] shift;
    logic [7:0] bit_cnt;
    logic [7:0] opcode;
    logic       opc_strobe;
    logic       id_ok;
    logic [2:0] id_idx;

    // Operation and power state.
    op_state_t             op_state;
    op_kind_t              cur_kind;
    logic [TIMER_W-1:0]    drain_cnt;
    pw_state_t             pw_state;
    logic [TIMER_W-1:0]    pw_tmr;

    // Decoded frame events.
    logic       end_short;
    logic       end_long;
    logic       id_phase;
    logic       suspend_go;
    logic       resume_go;
    logic       powerdown_go;
    logic       release_go;
    logic       release_id_go;

    // Only sector, block and page-type work can be paused.
    function automatic logic is_suspendable(input op_kind_t k);
        return (k == KIND_SECTOR_ERASE) || (k == KIND_BLOCK_ERASE) ||
               (k == KIND_PAGE_PROG);
    endfunction

    function automatic logic is_erase_kind(input op_kind_t k);
        return (k == KIND_SECTOR_ERASE) || (k == KIND_BLOCK_ERASE);
    endfunction

    // Opcodes refused while an operation of the given kind is paused.
    function automatic logic is_refused(input logic [7:0] opc, input op_kind_t k);
        logic erase_opc;
        logic prog_opc;
        erase_opc = (opc == OPC_SECTOR_ERASE) || (opc == OPC_BLOCK32_ERASE) ||
                    (opc == OPC_BLOCK64_ERASE) || (opc == OPC_CHIP_ERASE_A) ||
                    (opc == OPC_CHIP_ERASE_B) || (opc == OPC_SECREG_ERASE);
        prog_opc  = (opc == OPC_PAGE_PROG) || (opc == OPC_QUAD_PROG) ||
                    (opc == OPC_SECREG_PROG);
        if (opc == OPC_WRITE_STATUS) begin
            return 1'b1;
        end else if (is_erase_kind(k)) begin
            return erase_opc;
        end else if (k == KIND_PAGE_PROG) begin
            return prog_opc;
        end else begin
            return 1'b0;
        end
    endfunction

    function automatic logic is_own_opcode(input logic [7:0] opc);
        return (opc == OPC_SUSPEND) || (opc == OPC_RESUME) ||
               (opc == OPC_POWERDOWN) || (opc == OPC_RELEASE);
    endfunction

    // Select idles high, so its synchroniser resets to one.
    pin_sync #(
        .W       (3),
        .RST_VAL (3'b001)
    ) u_pin_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .pins     ({mosi, sclk, cs_n}),
        .level    ({mosi_s, sclk_s, cs_n_s}),
        .rise     (pin_rise),
        .fall     (pin_fall)
    );

    assign sclk_rise = pin_rise[1] & ~cs_n_s;
    assign sclk_fall = pin_fall[1] & ~cs_n_s;
    assign cs_rise   = pin_rise[0];

    // Bits are shifted in on rising clock edges while select is low.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            shift   <= 8'h00;
            bit_cnt <= 8'h00;
        end else if (cs_n_s) begin
            bit_cnt <= 8'h00;
        end else if (sclk_rise) begin
            shift <= {shift[6:0], mosi_s};
            if (bit_cnt != BITS_MAX) begin
                bit_cnt <= bit_cnt + 8'h01;
            end
        end
    end

    // The opcode is latched as its eighth bit arrives.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            opcode     <= 8'h00;
            opc_strobe <= 1'b0;
        end else begin
            opc_strobe <= sclk_rise && (bit_cnt == BITS_OPCODE - 8'h01);
            if (sclk_rise && (bit_cnt == BITS_OPCODE - 8'h01)) begin
                opcode <= {shift[6:0], mosi_s};
            end
        end
    end

    // A short frame ends exactly after eight bits; a long one after the dummies.
    assign end_short = cs_rise && (bit_cnt == BITS_OPCODE);
    assign end_long  = cs_rise && (bit_cnt >= BITS_ID_START);

    assign suspend_go = end_short && (opcode == OPC_SUSPEND) && (pw_state == PW_NORMAL) &&
                        !suspend_status_bit && busy &&
                        (op_state == OP_RUN) && is_suspendable(cur_kind);
    assign resume_go  = end_short && (opcode == OPC_RESUME) && (pw_state == PW_NORMAL) &&
                        suspend_status_bit && !busy && (op_state == OP_PAUSED);
    assign powerdown_go  = end_short && (opcode == OPC_POWERDOWN) &&
                           (pw_state == PW_NORMAL);
    assign release_go    = end_short && (opcode == OPC_RELEASE) &&
                           (pw_state == PW_DOWN) && !busy;
    assign release_id_go = end_long && (opcode == OPC_RELEASE) &&
                           (pw_state == PW_DOWN) && !busy;

    // Forwarding of all other opcodes in normal power state, with refusal of those that is_refused names while the suspend bit is set.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_opcode  <= 8'h00;
            cmd_valid   <= 1'b0;
            cmd_refused <= 1'b0;
            id_ok       <= 1'b0;
        end else begin
            cmd_valid   <= 1'b0;
            cmd_refused <= 1'b0;
            if (opc_strobe) begin
                id_ok <= (opcode == OPC_RELEASE) && !busy;
                if (pw_state == PW_NORMAL && !is_own_opcode(opcode)) begin
                    cmd_opcode <= opcode;
                    if (suspend_status_bit && is_refused(opcode, cur_kind)) begin
                        cmd_refused <= 1'b1;
                    end else begin
                        cmd_valid <= 1'b1;
                    end
                end
            end else if (cs_n_s) begin
                id_ok <= 1'b0;
            end
        end
    end

    // Identifier output, only in the frame that carried the release opcode.
    assign id_phase = !cs_n_s && id_ok && (bit_cnt >= BITS_ID_START) &&
                      (pw_state == PW_NORMAL || pw_state == PW_DOWN);

    // The identifier goes out on falling edges, most significant bit first, and wraps.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            miso    <= 1'b0;
            miso_oe <= 1'b0;
            id_idx  <= ID_MSB;
        end else if (cs_n_s) begin
            miso    <= 1'b0;
            miso_oe <= 1'b0;
            id_idx  <= ID_MSB;
        end else if (sclk_fall && id_phase) begin
            miso    <= DEVICE_ID[id_idx];
            miso_oe <= 1'b1;
            id_idx  <= id_idx - 3'h1;
        end
    end

    // Array operation sequence; an asynchronous reset stands for power loss.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            op_state           <= OP_IDLE;
            cur_kind           <= KIND_NONE;
            busy               <= 1'b0;
            suspend_status_bit <= 1'b0;
            drain_cnt          <= TIMER_ZERO;
        end else begin
            case (op_state)
                OP_IDLE: begin
                    if (op_start) begin
                        op_state <= OP_RUN;
                        cur_kind <= op_kind_t'(op_kind);
                        busy     <= 1'b1;
                    end
                end
                OP_RUN: begin
                    if (op_done) begin
                        op_state <= OP_IDLE;
                        cur_kind <= KIND_NONE;
                        busy     <= 1'b0;
                    end else if (suspend_go) begin
                        op_state           <= OP_DRAIN;
                        suspend_status_bit <= 1'b1;
                        drain_cnt          <= DRAIN_LOAD;
                    end
                end
                OP_DRAIN: begin
                    if (drain_cnt == TIMER_ZERO) begin
                        op_state <= OP_PAUSED;
                        busy     <= 1'b0;
                    end else begin
                        drain_cnt <= drain_cnt - TIMER_W'(1);
                    end
                end
                OP_PAUSED: begin
                    if (resume_go) begin
                        op_state           <= OP_RESUME;
                        suspend_status_bit <= 1'b0;
                    end
                end
                OP_RESUME: begin
                    // Busy returns one cycle after the resume, well inside the limit.
                    op_state <= OP_RUN;
                    busy     <= 1'b1;
                end
                default: begin
                    op_state <= OP_IDLE;
                    busy     <= 1'b0;
                end
            endcase
        end
    end

    // The engine stays held from the suspend until busy returns.
    assign op_hold = (op_state == OP_DRAIN) || (op_state == OP_PAUSED) ||
                     (op_state == OP_RESUME);

    // Power state; reset always lands in normal operation.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pw_state <= PW_NORMAL;
            pw_tmr   <= TIMER_ZERO;
        end else begin
            case (pw_state)
                PW_NORMAL: begin
                    if (powerdown_go) begin
                        pw_state <= PW_ENTER;
                        pw_tmr   <= ENTRY_LOAD;
                    end
                end
                PW_ENTER: begin
                    if (pw_tmr == TIMER_ZERO) begin
                        pw_state <= PW_DOWN;
                    end else begin
                        pw_tmr <= pw_tmr - TIMER_W'(1);
                    end
                end
                PW_DOWN: begin
                    if (release_go) begin
                        pw_state <= PW_RELEASE;
                        pw_tmr   <= RELEASE_LOAD;
                    end else if (release_id_go) begin
                        pw_state <= PW_RELEASE;
                        pw_tmr   <= RELEASE2_LOAD;
                    end
                end
                PW_RELEASE: begin
                    // Frames arriving before the release time ends are not acted on.
                    if (pw_tmr == TIMER_ZERO) begin
                        pw_state <= PW_NORMAL;
                    end else begin
                        pw_tmr <= pw_tmr - TIMER_W'(1);
                    end
                end
                default: begin
                    pw_state <= PW_NORMAL;
                end
            endcase
        end
    end

    assign powered_down = (pw_state == PW_DOWN);
    assign cmd_ready    = (pw_state == PW_NORMAL);

endmodule

// *** flash_srp_checker.sv ***
// Assertion checker for the suspend, resume and power-down command logic.
// Bound to the top module below; it sees only that module's ports.
`timescale 1ns/1ps
module flash_srp_checker
    import flash_ctl_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic       cs_n,
    input wire logic       miso_oe,
    input wire logic       op_hold,
    input wire logic       busy,
    input wire logic       suspend_status_bit,
    input wire logic       powered_down,
    input wire logic       cmd_ready,
    input wire logic [7:0] cmd_opcode,
    input wire logic       cmd_valid,
    input wire logic       cmd_refused
);
    localparam int SUS_MAX = 800;
    logic [7:0] rel_cnt;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // Counts cycles spent neither ready nor powered down, so a short release shows up.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rel_cnt <= 8'h00;
        end else if (powered_down || cmd_ready) begin
            rel_cnt <= 8'h00;
        end else if (rel_cnt != 8'hff) begin
            rel_cnt <= rel_cnt + 8'h01;
        end
    end

    property p_susp_set;
        $rose(suspend_status_bit) |-> busy && op_hold;
    endproperty
    a_susp_set: assert property (p_susp_set)
        else $error("suspend set while idle or without hold");
    property p_drain;
        $rose(suspend_status_bit) |-> ##[1:SUS_MAX] !busy;
    endproperty
    a_drain: assert property (p_drain)
        else $error("busy did not clear after suspend");
    property p_resume_idle;
        $fell(suspend_status_bit) |-> !$past(busy);
    endproperty
    a_resume_idle: assert property (p_resume_idle)
        else $error("resume acted while busy");
    property p_resume_busy;
        $fell(suspend_status_bit) |-> ##[0:8] busy;
    endproperty
    a_resume_busy: assert property (p_resume_busy)
        else $error("busy late after resume");
    property p_pd_entry;
        $fell(cmd_ready) |-> ##[1:121] powered_down;
    endproperty
    a_pd_entry: assert property (p_pd_entry)
        else $error("power-down entry too slow");
    property p_down_quiet;
        powered_down |-> !cmd_valid && !cmd_refused;
    endproperty
    a_down_quiet: assert property (p_down_quiet)
        else $error("command forwarded while powered down");
    property p_release_time;
        $rose(cmd_ready) |-> rel_cnt >= 8'h46;
    endproperty
    a_release_time: assert property (p_release_time)
        else $error("ready too soon after release");
    property p_no_status_write;
        cmd_valid && suspend_status_bit |-> cmd_opcode != OPC_WRITE_STATUS;
    endproperty
    a_no_status_write: assert property (p_no_status_write)
        else $error("status write forwarded while suspended");
    property p_miso_off;
        $rose(cs_n) |-> ##[0:6] !miso_oe;
    endproperty
    a_miso_off: assert property (p_miso_off)
        else $error("output still driven after select rose");

    c_suspend: cover property ($rose(suspend_status_bit));
    c_down: cover property ($rose(powered_down));
    c_id: cover property ($rose(miso_oe));
endmodule

bind flash_suspend_resume_powerdown flash_srp_checker flash_srp_checker_inst (
    .core_clk(core_clk), .rstn(rstn), .cs_n(cs_n), .miso_oe(miso_oe), .op_hold(op_hold),
    .busy(busy), .suspend_status_bit(suspend_status_bit), .powered_down(powered_down),
    .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode), .cmd_valid(cmd_valid),
    .cmd_refused(cmd_refused));

// *** flash_host_model.sv ***
// Serial host model: drives select, clock and data and reads the identifier back.
// The serial clock stands low between frames; one bit takes 200 ns.
`timescale 1ns/1ps
module flash_host_model (
    // Serial pins
    output logic      cs_n,
    output logic      sclk,
    output logic      mosi,
    input  wire logic miso
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end

    // Sends nbits from the top of data, then clocks rbits more and shifts miso in.
    task automatic xfer(input logic [31:0] data, input int nbits, input int rbits,
                        output logic [15:0] rd);
        rd = 16'h0000;
        #13 cs_n = 1'b0;
        for (int i = 0; i < nbits + rbits; i++) begin
            mosi = (i < nbits) ? data[31 - i] : ~mosi;
            #100 sclk = 1'b1;
            #100;
            rd = (i >= nbits) ? {rd[14:0], miso} : rd;
            sclk = 1'b0;
        end
        // Select rises right after the last bit; the data line is then not held.
        #50 cs_n = 1'b1;
        mosi = ~mosi;
        #200;
    endtask
endmodule

// *** flash_suspend_resume_powerdown_bench.sv ***
// Self-checking bench for the suspend, resume and power-down command logic.
// Engine pins are driven here; serial pins go through the host model.
`timescale 1ns/1ps
module flash_suspend_resume_powerdown_bench
    import flash_ctl_pkg::*;
;
    localparam logic [7:0] DEV_ID = 8'h3c; // Arbitrary identifier value.
    logic        core_clk, rstn, cs_n, sclk, mosi, miso, miso_oe, op_start, op_done;
    logic        op_hold, busy, suspend_status_bit, powered_down, cmd_ready;
    logic        cmd_valid, cmd_refused, seen_valid, seen_ref, seen_oe;
    logic [2:0]  op_kind;
    logic [7:0]  cmd_opcode;
    logic [15:0] rd;
    logic [7:0]  refq[$];
    int          num_errors, n_compared, cycles, seed, m_busy, m_sus, m_pd;
    logic [2:0]  kinds[3] = '{3'h1, 3'h2, 3'h4};

    flash_suspend_resume_powerdown #(.DEVICE_ID(DEV_ID)) flash_suspend_resume_powerdown_inst (
        .core_clk(core_clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .op_start(op_start), .op_kind(op_kind),
        .op_done(op_done), .op_hold(op_hold), .busy(busy),
        .suspend_status_bit(suspend_status_bit), .powered_down(powered_down),
        .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode), .cmd_valid(cmd_valid),
        .cmd_refused(cmd_refused));
    flash_host_model flash_host_model_inst (.cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso));

    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        seen_valid = seen_valid | (cmd_valid === 1'b1);
        seen_ref = seen_ref | (cmd_refused === 1'b1);
        seen_oe = seen_oe | (miso_oe === 1'b1);
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (num_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic check_model();
        check("busy", 16'(busy), 16'(m_busy));
        check("suspend", 16'(suspend_status_bit), 16'(m_sus));
        check("powered_down", 16'(powered_down), 16'(m_pd));
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    task automatic send(input logic [7:0] op, input int nbits, input int rbits);
        flash_host_model_inst.xfer({op, 24'($random(seed))}, nbits, rbits, rd);
        cyc(8);
    endtask

    // Waits for busy low (0), power-down (1) or ready (2) under a bounded count.
    task automatic wait_until(input int w, input int lim);
        int n;
        n = 0;
        while (n < lim && (w == 0 ? ~busy : (w == 1 ? powered_down : cmd_ready)) !== 1'b1) begin
            cyc(1);
            n++;
        end
    endtask

    task automatic op_pulse(input logic [2:0] kind, input logic done);
        op_kind = kind;
        op_start = ~done;
        op_done = done;
        cyc(1);
        op_start = 1'b0;
        op_done = 1'b0;
        m_busy = !done;
        cyc(1);
    endtask

    initial begin
        seed = 32'haf51375a;
        {num_errors, n_compared, cycles, m_busy, m_sus, m_pd} = '0;
        {rstn, op_start, op_done, op_kind, seen_valid, seen_ref, seen_oe} = '0;
        repeat (4) @(posedge core_clk);
        #2 rstn = 1'b1;
        cyc(2);
        check_model();
        check("ready", 16'(cmd_ready), 16'h0001);
        send(OPC_SUSPEND, 8, 0);
        send(OPC_RESUME, 8, 0);
        check_model();
        seen_valid = 1'b0;
        send(OPC_WRITE_STATUS, 8, 0);
        check("forwarded", 16'(seen_valid), 16'h0001);
        for (int k = 0; k < 3; k++) begin
            op_pulse(kinds[k], 1'b0);
            cyc(2 + ($random(seed) & 15));
            send(OPC_SUSPEND, 8, 0);
            m_sus = 1;
            check_model();
            check("hold", 16'(op_hold), 16'h0001);
            wait_until(0, 900);
            m_busy = 0;
            check_model();
            send(OPC_SUSPEND, 8, 0);
            check_model();
            if (kinds[k] == 3'h4) begin
                refq = '{OPC_WRITE_STATUS, OPC_PAGE_PROG, OPC_QUAD_PROG, OPC_SECREG_PROG};
            end else begin
                refq = '{OPC_WRITE_STATUS, OPC_SECTOR_ERASE, OPC_BLOCK32_ERASE,
                         OPC_BLOCK64_ERASE, OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B,
                         OPC_SECREG_ERASE};
            end
            foreach (refq[i]) begin
                seen_ref = 1'b0;
                send(refq[i], 8, 0);
                check("refused", 16'(seen_ref), 16'h0001);
                check("opcode", 16'(cmd_opcode), 16'(refq[i]));
            end
            seen_valid = 1'b0;
            send((kinds[k] == 3'h4) ? OPC_SECTOR_ERASE : OPC_PAGE_PROG, 8, 0);
            check("other_access", 16'(seen_valid), 16'h0001);
            send(OPC_RESUME, 8, 0);
            m_sus = 0;
            m_busy = 1;
            check_model();
            cyc(SUSPEND_LATENCY_CYC);
            op_pulse(kinds[k], 1'b1);
        end
        op_pulse(3'h3, 1'b0);
        send(OPC_SUSPEND, 8, 0);
        check_model();
        op_pulse(3'h3, 1'b1);
        seen_oe = 1'b0;
        send(OPC_RELEASE, 32, 16);
        check("id", rd, {DEV_ID, DEV_ID});
        check("oe", 16'(seen_oe), 16'h0001);
        op_pulse(3'h1, 1'b0);
        seen_oe = 1'b0;
        send(OPC_RELEASE, 32, 16);
        check("oe_busy", 16'(seen_oe), 16'h0000);
        op_pulse(3'h1, 1'b1);
        send(OPC_POWERDOWN, 9, 0);
        cyc(130);
        check_model();
        send(OPC_POWERDOWN, 8, 0);
        wait_until(1, 200);
        m_pd = 1;
        check_model();
        seen_valid = 1'b0;
        send(8'h05, 8, 0);
        send(OPC_SUSPEND, 8, 0);
        check("quiet", 16'(seen_valid), 16'h0000);
        check_model();
        send(OPC_RELEASE, 8, 0);
        m_pd = 0;
        check_model();
        wait_until(2, 200);
        check("ready", 16'(cmd_ready), 16'h0001);
        send(OPC_POWERDOWN, 8, 0);
        wait_until(1, 200);
        send(OPC_RELEASE, 32, 8);
        check("id_release", rd, {8'h00, DEV_ID});
        wait_until(2, 200);
        check("ready", 16'(cmd_ready), 16'h0001);
        op_pulse(3'h2, 1'b0);
        send(OPC_SUSPEND, 8, 0);
        cyc(5);
        rstn = 1'b0;
        cyc(2);
        rstn = 1'b1;
        m_sus = 0;
        m_busy = 0;
        check_model();
        send(OPC_RESUME, 8, 0);
        check_model();
        op_pulse(3'h2, 1'b0);
        check_model();
        op_pulse(3'h2, 1'b1);
        report_and_stop();
    end
endmodule
